// ===== common/pba_pkg.sv
// shared constants and types for the priority bus arbiter and requester
package pba_pkg;

  // ----------------------------------------------------------------
  // clock and bus geometry
  // ----------------------------------------------------------------
  localparam int PBA_CLK_PERIOD_NS = 25;
  localparam int PBA_LEVELS = 4;
  localparam int PBA_REQ_HI = 3;
  localparam int PBA_REQ_MID = 2;

  // ----------------------------------------------------------------
  // owner levels
  // ----------------------------------------------------------------
  localparam logic [1:0] PBA_OWNER_UNINTERRUPTIBLE = 2'h3;
  localparam logic [1:0] PBA_OWNER_SUSPENDABLE = 2'h0;
  localparam logic [1:0] PBA_OWNER_RESET = 2'h0;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [3:0] PBA_LINES_IDLE_N = 4'hf;
  localparam logic [3:0] PBA_LINES_OFF = 4'h0;

  // ----------------------------------------------------------------
  // timeout loop
  // ----------------------------------------------------------------
  localparam logic [5:0] PBA_TIMEOUT_LOAD = 6'h3f;
  localparam logic [5:0] PBA_TIMEOUT_ZERO = 6'h00;
  localparam logic [1:0] PBA_LOOP_CYCLES = 2'h3;
  localparam logic [1:0] PBA_LOOP_FIRST = 2'h0;
  localparam int PBA_TIMEOUT_NS = int'(PBA_LOOP_CYCLES) * PBA_CLK_PERIOD_NS * (int'(PBA_TIMEOUT_LOAD) + 1);
  localparam int PBA_TIMEOUT_CYCLES = PBA_TIMEOUT_NS / PBA_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // requester states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    PBA_ST_IDLE = 5'h01,
    PBA_ST_REQUEST = 5'h02,
    PBA_ST_OWNED = 5'h04,
    PBA_ST_XFER = 5'h08,
    PBA_ST_RELEASE = 5'h10
  } pba_state_e;

endpackage

// ===== core/pba_arbiter.sv
// priority arbiter: grant, owner level and bus clear
`timescale 1ns/1ps
`default_nettype none
module pba_arbiter (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_req,
  input wire logic i_busy,
  output logic [3:0] o_grant_n,
  output logic [1:0] o_owner,
  output logic o_clear_n
);

  // ----------------------------------------------------------------
  // parallel priority decode
  // ----------------------------------------------------------------
  wire any_req = |i_req;
  wire [1:0] win_level = i_req[3] ? 2'h3 : i_req[2] ? 2'h2 : i_req[1] ? 2'h1 : 2'h0;
  wire [3:0] win_onehot = any_req ? 4'(4'h1 << win_level) : pba_pkg::PBA_LINES_OFF;
  wire grant_pending = ~&o_grant_n;
  wire held_req = |(~o_grant_n & i_req);
  wire owner_locked = (o_owner == pba_pkg::PBA_OWNER_UNINTERRUPTIBLE);
  wire hi_req = i_req[pba_pkg::PBA_REQ_HI] | i_req[pba_pkg::PBA_REQ_MID];
  wire clear_cond = i_busy & ~owner_locked &
                    (hi_req | ((o_owner == pba_pkg::PBA_OWNER_SUSPENDABLE) & any_req));
  wire issue = ~i_busy & ~grant_pending & any_req;

  wire [3:0] next_grant_n = i_busy ? pba_pkg::PBA_LINES_IDLE_N :
                            grant_pending ? (held_req ? o_grant_n : pba_pkg::PBA_LINES_IDLE_N) :
                            ~win_onehot;
  wire next_clear = i_busy & (~o_clear_n | clear_cond);
  wire [1:0] next_owner = issue ? win_level : o_owner;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_grant_n <= pba_pkg::PBA_LINES_IDLE_N;
      o_owner <= pba_pkg::PBA_OWNER_RESET;
      o_clear_n <= 1'b1;
    end else begin
      o_grant_n <= next_grant_n;
      o_owner <= next_owner;
      o_clear_n <= ~next_clear;
    end
  end

endmodule
`default_nettype wire

// ===== core/pba_timeout.sv
// six-bit transfer timeout loop counter
`timescale 1ns/1ps
`default_nettype none
module pba_timeout (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic i_ack,
  output logic o_expired,
  output logic o_running
);

  logic [5:0] count;
  logic [1:0] pass;

  // ----------------------------------------------------------------
  // loop pass decode
  // ----------------------------------------------------------------
  wire pass_end = (pass == 2'(pba_pkg::PBA_LOOP_CYCLES - 2'h1));
  wire at_zero = (count == pba_pkg::PBA_TIMEOUT_ZERO);
  wire stop_ack = o_running & i_ack;
  wire expire = o_running & ~i_ack & pass_end & at_zero;

  // expiry is shown in the last cycle of the final pass so the abort lands on the interval end
  assign o_expired = expire & ~i_load;

  wire next_running = i_load | (o_running & ~stop_ack & ~expire);
  wire [1:0] next_pass = (i_load | pass_end) ? pba_pkg::PBA_LOOP_FIRST : 2'(pass + 2'h1);
  wire [5:0] next_count = i_load ? pba_pkg::PBA_TIMEOUT_LOAD :
                          (o_running & pass_end & ~at_zero) ? 6'(count - 6'h01) : count;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count <= pba_pkg::PBA_TIMEOUT_ZERO;
      pass <= pba_pkg::PBA_LOOP_FIRST;
      o_running <= 1'b0;
    end else begin
      count <= next_count;
      pass <= next_pass;
      o_running <= next_running;
    end
  end

endmodule
`default_nettype wire

// ===== core/pba_top.sv
// bus slot with priority arbiter and master requester
`timescale 1ns/1ps
`default_nettype none
module pba_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_bus_req_n,
  input wire logic i_bus_busy_n,
  input wire logic i_bus_clear_n,
  input wire logic [3:0] i_grant_in_n,
  input wire logic [1:0] i_req_level,
  input wire logic i_local_req,
  input wire logic i_local_start,
  input wire logic i_xfer_ack_n,
  output logic [3:0] o_bus_grant_n,
  output logic o_bus_clear_n,
  output logic [1:0] o_owner_level,
  output logic [3:0] o_grant_out_n,
  output logic [3:0] o_bus_req_n,
  output logic [3:0] o_bus_req_oe,
  output logic o_bus_busy_n,
  output logic o_bus_busy_oe,
  output logic o_local_owned,
  output logic o_xfer_active,
  output logic o_xfer_done,
  output logic o_transfer_timeout_flag
);

  // ----------------------------------------------------------------
  // arbiter
  // ----------------------------------------------------------------
  wire [3:0] bus_req = ~i_bus_req_n;
  wire bus_busy = ~i_bus_busy_n;

  pba_arbiter u_arbiter (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_req(bus_req),
    .i_busy(bus_busy),
    .o_grant_n(o_bus_grant_n),
    .o_owner(o_owner_level),
    .o_clear_n(o_bus_clear_n)
  );

  // ----------------------------------------------------------------
  // requester state
  // ----------------------------------------------------------------
  pba_pkg::pba_state_e state;
  pba_pkg::pba_state_e next_state;

  wire xfer_ack = ~i_xfer_ack_n;
  wire bus_clear = ~i_bus_clear_n;
  wire own_grant = ~i_grant_in_n[i_req_level];
  wire [3:0] level_onehot = 4'(4'h1 << i_req_level);

  wire st_idle = (state == pba_pkg::PBA_ST_IDLE);
  wire st_request = (state == pba_pkg::PBA_ST_REQUEST);
  wire st_owned = (state == pba_pkg::PBA_ST_OWNED);
  wire st_xfer = (state == pba_pkg::PBA_ST_XFER);

  // ----------------------------------------------------------------
  // transfer timeout
  // ----------------------------------------------------------------
  wire tmo_expired;
  wire tmo_running;
  wire xfer_load = st_owned & i_local_start & i_local_req & ~bus_clear;

  pba_timeout u_timeout (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(xfer_load),
    .i_ack(xfer_ack),
    .o_expired(tmo_expired),
    .o_running(tmo_running)
  );

  // ----------------------------------------------------------------
  // sequence decisions
  // ----------------------------------------------------------------
  wire take_bus = st_request & own_grant & ~bus_busy;
  wire drop_local = st_owned & ~i_local_req;
  wire yield_bus = st_owned & i_local_req & bus_clear;
  wire xfer_ok = st_xfer & xfer_ack;
  wire xfer_abort = st_xfer & ~xfer_ack & tmo_expired;

  always_comb begin
    next_state = state;
    case (state)
      pba_pkg::PBA_ST_IDLE: begin
        if (i_local_req) begin
          next_state = pba_pkg::PBA_ST_REQUEST;
        end
      end
      pba_pkg::PBA_ST_REQUEST: begin
        if (!i_local_req) begin
          next_state = pba_pkg::PBA_ST_IDLE;
        end else if (take_bus) begin
          next_state = pba_pkg::PBA_ST_OWNED;
        end
      end
      pba_pkg::PBA_ST_OWNED: begin
        if (drop_local || yield_bus) begin
          next_state = pba_pkg::PBA_ST_RELEASE;
        end else if (xfer_load) begin
          next_state = pba_pkg::PBA_ST_XFER;
        end
      end
      pba_pkg::PBA_ST_XFER: begin
        if (xfer_ok || xfer_abort) begin
          next_state = pba_pkg::PBA_ST_OWNED;
        end
      end
      pba_pkg::PBA_ST_RELEASE: begin
        next_state = pba_pkg::PBA_ST_IDLE;
      end
      default: begin
        next_state = pba_pkg::PBA_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // grant daisy chain
  // ----------------------------------------------------------------
  wire keep_grant = (st_request & i_local_req) | take_bus;
  wire [3:0] next_grant_out_n;

  genvar k;
  generate
    for (k = 0; k < pba_pkg::PBA_LEVELS; k = k + 1) begin : g_chain
      assign next_grant_out_n[k] = i_grant_in_n[k] | (keep_grant & level_onehot[k]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // bus line drive
  // ----------------------------------------------------------------
  wire next_req_drive = (st_idle & i_local_req) | (st_request & i_local_req & ~take_bus);
  wire [3:0] next_req_oe = next_req_drive ? level_onehot : pba_pkg::PBA_LINES_OFF;
  wire next_busy_drive = (next_state == pba_pkg::PBA_ST_OWNED) | (next_state == pba_pkg::PBA_ST_XFER);
  wire next_owned = next_busy_drive;
  wire next_active = (next_state == pba_pkg::PBA_ST_XFER);

  // ----------------------------------------------------------------
  // timeout flag: a new expiry wins over the clear
  // ----------------------------------------------------------------
  wire flag_clear = xfer_load | (next_state == pba_pkg::PBA_ST_IDLE);
  wire next_flag = xfer_abort | (o_transfer_timeout_flag & ~flag_clear);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= pba_pkg::PBA_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_grant_out_n <= pba_pkg::PBA_LINES_IDLE_N;
      o_bus_req_oe <= pba_pkg::PBA_LINES_OFF;
      o_bus_req_n <= pba_pkg::PBA_LINES_IDLE_N;
    end else begin
      o_grant_out_n <= next_grant_out_n;
      o_bus_req_oe <= next_req_oe;
      o_bus_req_n <= ~next_req_oe;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bus_busy_oe <= 1'b0;
      o_bus_busy_n <= 1'b1;
      o_local_owned <= 1'b0;
      o_xfer_active <= 1'b0;
    end else begin
      o_bus_busy_oe <= next_busy_drive;
      o_bus_busy_n <= ~next_busy_drive;
      o_local_owned <= next_owned;
      o_xfer_active <= next_active;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_xfer_done <= 1'b0;
      o_transfer_timeout_flag <= 1'b0;
    end else begin
      o_xfer_done <= xfer_ok;
      o_transfer_timeout_flag <= next_flag;
    end
  end

  wire unused_running = tmo_running;

endmodule
`default_nettype wire

// ===== testbench/pba_top_sva.sv
// checker for the bus slot top
`timescale 1ns/1ps
`default_nettype none
module pba_top_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_bus_req_n,
  input wire logic i_bus_busy_n,
  input wire logic i_bus_clear_n,
  input wire logic [3:0] i_grant_in_n,
  input wire logic [1:0] i_req_level,
  input wire logic i_local_req,
  input wire logic i_local_start,
  input wire logic i_xfer_ack_n,
  input wire logic [3:0] o_bus_grant_n,
  input wire logic o_bus_clear_n,
  input wire logic [1:0] o_owner_level,
  input wire logic [3:0] o_grant_out_n,
  input wire logic [3:0] o_bus_req_oe,
  input wire logic o_bus_busy_n,
  input wire logic o_bus_busy_oe,
  input wire logic o_local_owned,
  input wire logic o_xfer_active,
  input wire logic o_xfer_done,
  input wire logic o_transfer_timeout_flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] tmo_cnt;
  wire [3:0] req_top = !i_bus_req_n[3] ? 4'h8 : !i_bus_req_n[2] ? 4'h4 : !i_bus_req_n[1] ? 4'h2 : {3'h0, !i_bus_req_n[0]};
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) tmo_cnt <= 8'h00;
    else tmo_cnt <= o_xfer_active ? tmo_cnt + 8'h01 : 8'h00;
  end
  property p_grant_top;
    (o_bus_grant_n != 4'hf && $past(o_bus_grant_n) == 4'hf) |-> ~o_bus_grant_n == $past(req_top);
  endproperty
  a_grant_top: assert property (p_grant_top) else $error("grant not on highest line");
  property p_grant_free;
    (o_bus_grant_n != 4'hf && $past(o_bus_grant_n) == 4'hf) |-> $past(i_bus_busy_n) && ~o_bus_grant_n == (4'h1 << o_owner_level);
  endproperty
  a_grant_free: assert property (p_grant_free) else $error("grant on busy bus or owner wrong");
  property p_grant_one;
    $onehot0(~o_bus_grant_n);
  endproperty
  a_grant_one: assert property (p_grant_one) else $error("several grants");
  property p_clear_set;
    (!i_bus_busy_n && ((o_owner_level != 2'h3 && !(i_bus_req_n[3] && i_bus_req_n[2]))
      || (o_owner_level == 2'h0 && i_bus_req_n != 4'hf))) |=> !o_bus_clear_n;
  endproperty
  a_clear_set: assert property (p_clear_set) else $error("clear not raised");
  property p_clear_hold;
    !o_bus_clear_n && !i_bus_busy_n |=> !o_bus_clear_n;
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("clear dropped early");
  property p_clear_drop;
    !o_bus_clear_n && i_bus_busy_n |=> o_bus_clear_n;
  endproperty
  a_clear_drop: assert property (p_clear_drop) else $error("clear not dropped");
  property p_owner3;
    o_owner_level == 2'h3 && o_bus_clear_n |=> o_bus_clear_n;
  endproperty
  a_owner3: assert property (p_owner3) else $error("clear for top owner");
  property p_chain;
    !$past(i_local_req) |-> o_grant_out_n == $past(i_grant_in_n);
  endproperty
  a_chain: assert property (p_chain) else $error("grant chain not passed on");
  property p_block;
    o_bus_req_oe != 4'h0 |-> o_bus_req_oe == 4'(4'h1 << i_req_level) && !o_local_owned;
  endproperty
  a_block: assert property (p_block) else $error("request on wrong line");
  property p_owned;
    o_local_owned |-> o_bus_busy_oe && !o_bus_busy_n;
  endproperty
  a_owned: assert property (p_owned) else $error("owned without busy");
  property p_start;
    (o_local_owned && !o_xfer_active && !o_xfer_done && i_local_start && i_local_req && i_bus_clear_n) |=> o_xfer_active;
  endproperty
  a_start: assert property (p_start) else $error("transfer not started");
  property p_ack;
    o_xfer_active && !i_xfer_ack_n |=> o_xfer_done && !o_xfer_active ##1 !o_xfer_done;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not ending loop");
  property p_timeout;
    $rose(o_transfer_timeout_flag) |-> $past(tmo_cnt) == 8'hbf && !o_xfer_active;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout length wrong");
  property p_release;
    (o_local_owned && !o_xfer_active && (!i_local_req || !i_bus_clear_n)) |=> !o_bus_busy_oe && !o_local_owned;
  endproperty
  a_release: assert property (p_release) else $error("busy not released");
endmodule
bind pba_top pba_top_chk i_chk (.i_clk, .i_rst, .i_bus_req_n, .i_bus_busy_n, .i_bus_clear_n, .i_grant_in_n,
  .i_req_level, .i_local_req, .i_local_start, .i_xfer_ack_n, .o_bus_grant_n, .o_bus_clear_n, .o_owner_level,
  .o_grant_out_n, .o_bus_req_oe,
  .o_bus_busy_n, .o_bus_busy_oe, .o_local_owned, .o_xfer_active, .o_xfer_done, .o_transfer_timeout_flag);
`default_nettype wire

// ===== testbench/pba_master_model.sv
// local master device and slave model on the far side of the requester
`timescale 1ns/1ps
`default_nettype none
module pba_master_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic i_hold,
  input wire logic [7:0] i_ack_dly,
  input wire logic i_owned,
  input wire logic i_active,
  input wire logic i_done,
  input wire logic i_flag,
  output logic o_local_req,
  output logic o_local_start,
  output logic o_ack_n
);
  logic started, was_owned;
  logic [7:0] cnt;
  always @(negedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {o_local_req, o_local_start, started, was_owned, cnt} <= 12'h000;
      o_ack_n <= 1'b1;
    end else begin
      o_local_start <= 1'b0;
      was_owned <= i_owned;
      if (i_go) o_local_req <= 1'b1;
      if (i_owned && o_local_req && !started && !i_hold) begin
        o_local_start <= 1'b1;
        started <= 1'b1;
      end
      if (i_active) cnt <= cnt + 8'h01;
      if (i_active && i_ack_dly != 8'h00 && cnt == i_ack_dly) o_ack_n <= 1'b0;
      if (i_done || i_flag || (was_owned && !i_owned)) begin
        o_local_req <= 1'b0;
        o_ack_n <= 1'b1;
        started <= 1'b0;
        cnt <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/pba_top_tb.sv
// self-checking testbench for the bus slot top
`timescale 1ns/1ps
`default_nettype none
module pba_top_tb;
  logic i_clk = 1'b0, i_rst = 1'b1, tb_busy_n = 1'b1, go = 1'b0, hold = 1'b0;
  logic [3:0] tb_req_n = 4'hf;
  logic [1:0] lvl = 2'h0;
  logic [7:0] ack_dly = 8'h00;
  int num_errors = 0, num_checks = 0;
  wire [3:0] grant_n, req_o, req_oe, gout;
  wire [1:0] owner;
  wire clr_n, busy_o, busy_oe, owned, active, done, flag, lreq, lstart, ack_n;
  wire [3:0] bus_req_n = tb_req_n & (~req_oe | req_o);
  wire bus_busy_n = tb_busy_n & (~busy_oe | busy_o);
  always #12.5 i_clk = ~i_clk;
  pba_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_bus_req_n(bus_req_n), .i_bus_busy_n(bus_busy_n),
    .i_bus_clear_n(clr_n), .i_grant_in_n(grant_n), .i_req_level(lvl), .i_local_req(lreq), .i_local_start(lstart),
    .i_xfer_ack_n(ack_n), .o_bus_grant_n(grant_n), .o_bus_clear_n(clr_n), .o_owner_level(owner),
    .o_grant_out_n(gout), .o_bus_req_n(req_o), .o_bus_req_oe(req_oe), .o_bus_busy_n(busy_o),
    .o_bus_busy_oe(busy_oe), .o_local_owned(owned), .o_xfer_active(active), .o_xfer_done(done),
    .o_transfer_timeout_flag(flag));
  pba_master_model i_master (.i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_hold(hold), .i_ack_dly(ack_dly),
    .i_owned(owned), .i_active(active), .i_done(done), .i_flag(flag), .o_local_req(lreq),
    .o_local_start(lstart), .o_ack_n(ack_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic complete_run;
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_reset;
    check({grant_n, owner, clr_n, busy_oe}, 8'hf2);
    check({req_oe, owned, active, done, flag}, 8'h00);
  endtask
  task automatic t_arb;
    logic e;
    for (int t = 0; t < 4; t++) begin
      tb_req_n = ~((4'h2 << t) - 4'h1);
      cyc(1);
      check({grant_n, 2'h0, owner}, {~(4'h1 << t), 2'h0, 2'(t)});
      tb_busy_n = 1'b0;
      tb_req_n = 4'hf;
      cyc(2);
      for (int q = 0; q < 4; q++) begin
        tb_busy_n = 1'b0;
        tb_req_n = ~(4'h1 << q);
        e = (t != 3 && q >= 2) || t == 0;
        cyc(2);
        check({grant_n, 3'h0, clr_n}, {4'hf, 3'h0, !e});
        cyc(1);
        check(clr_n, !e);
        tb_busy_n = 1'b1;
        tb_req_n = 4'hf;
        cyc(2);
        check(clr_n, 1'b1);
      end
    end
  endtask
  task automatic t_xfer(input logic [7:0] dly);
    int n, m;
    lvl = 2'h1;
    ack_dly = dly;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    for (n = 0; owned !== 1'b1 && n < 20; n++) cyc(1);
    check({owned, busy_oe, gout[1]}, 8'h07);
    for (n = 0; active !== 1'b1 && n < 20; n++) cyc(1);
    for (m = 0; done !== 1'b1 && flag !== 1'b1 && m < 300; m++) cyc(1);
    if (dly == 8'h00) check(m, 8'hc0);
    else check(m < 192, 1'b1);
    check({done, flag, active}, {dly != 8'h00, dly == 8'h00, 1'b0});
    for (n = 0; busy_oe !== 1'b0 && n < 20; n++) cyc(1);
    check({busy_oe, owned}, 8'h00);
    cyc(3);
  endtask
  task automatic t_clear;
    int n;
    lvl = 2'h0;
    hold = 1'b1;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    for (n = 0; owned !== 1'b1 && n < 20; n++) cyc(1);
    tb_req_n = 4'h7;
    for (n = 0; busy_oe !== 1'b0 && n < 20; n++) cyc(1);
    check({busy_oe, owned}, 8'h00);
    for (n = 0; grant_n !== 4'h7 && n < 20; n++) cyc(1);
    check(grant_n, 4'h7);
    tb_req_n = 4'hf;
    hold = 1'b0;
    cyc(4);
  endtask
  initial begin
    cyc(1);
    t_reset();
    cyc(1);
    i_rst = 1'b0;
    t_arb();
    t_xfer(8'h04);
    t_xfer(8'h00);
    t_clear();
    complete_run();
  end
  initial begin
    #(25 * 5000);
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
